// [sdg_core.sv]
// Serial register port diagnostics: clock count, address, busy and checksum checks
// Function
// - Flag pulse counts not a multiple of eight
// - Drop writes with too few pulses
// - Pulse counting always runs; only the count check has an enable
// - Bad read address flags and reads zero
// - Bad or read-only write flags and aborts
// - No access while defaults load; host waits
// - Refuse access during calibration or sequence
// - Ignore flag marks blocked periods, default on
// - Writes dropped while ignore flag set; W1C
// - Checksum polynomial x^8 + x^2 + x + 1
// - Remainder of zero-extended message, eight bits
// - Bad write checksum flags and aborts
// - Checksum byte follows data when enabled
// - Device sums command plus read data
// - Continuous readout sums implied 0x42 first
// - Map checksum skips volatile registers
// - Map checksum checked every 1/300 s
// - Map checksum retaken after listed events
// - Map mismatch flags when enabled
// - ROM checksum at power-up flags mismatch
// - ROM check keeps master clock in standby
`timescale 1ns/1ps
`default_nettype none
module sdg_core #(
  parameter int REGMAP_PERIOD = sdg_pkg::REGMAP_PERIOD_CYC,
  parameter int ROM_BYTES     = sdg_pkg::ROM_BYTES_DEF,
  parameter int MAP_BYTES     = sdg_pkg::MAP_BYTES_DEF
) (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RESET_N,
  input  wire logic                        SCLK,
  input  wire logic                        CS_N,
  input  wire logic                        SDI,
  output logic                             SDO,
  output logic                             SDO_OE,
  output logic [sdg_pkg::ADDR_W-1:0]       REG_ADDR,
  output logic [31:0]                      REG_WDATA,
  output logic                             REG_WE,
  input  wire logic [31:0]                 REG_RDATA,
  input  wire logic [2:0]                  REG_WIDTH,
  input  wire logic                        REG_VALID,
  input  wire logic                        REG_READ_ONLY,
  input  wire logic                        CONTINUOUS_READOUT,
  input  wire logic                        CALIBRATING,
  input  wire logic                        SEQUENCE_BUSY,
  input  wire logic                        CAL_DONE,
  input  wire logic                        SEQ_STANDBY_ENTRY,
  input  wire logic                        CLOCK_COUNT_CHECK_ENABLE,
  input  wire logic                        READ_CHECK_ENABLE,
  input  wire logic                        WRITE_CHECK_ENABLE,
  input  wire logic                        IGNORE_CHECK_DISABLE,
  input  wire logic                        CHECKSUM_ENABLE,
  input  wire logic                        REGMAP_CHECKSUM_ENABLE,
  input  wire logic                        ROM_CHECK_ENABLE,
  input  wire logic                        MASTER_CLOCK_ENABLE,
  input  wire logic [sdg_pkg::N_FAULTS-1:0] FAULT_CLEAR,
  output logic [$clog2(ROM_BYTES)-1:0]     ROM_ADDR,
  input  wire logic [7:0]                  ROM_DATA,
  input  wire logic [7:0]                  ROM_CHECKSUM_REF,
  output logic [$clog2(MAP_BYTES)-1:0]     MAP_ADDR,
  input  wire logic [7:0]                  MAP_DATA,
  input  wire logic                        MAP_SKIP,
  output logic                             LOADING,
  output logic                             KEEP_CLOCK_ALIVE,
  output logic                             CLOCK_COUNT_FAULT,
  output logic                             READ_FAULT,
  output logic                             WRITE_FAULT,
  output logic                             IGNORE_FAULT,
  output logic                             CHECKSUM_FAULT,
  output logic                             REGMAP_CHECKSUM_FAULT,
  output logic                             ROM_CHECKSUM_FAULT
);
  logic [2:0]          s1_q;
  logic [2:0]          s2_q;
  logic [2:0]          s3_q;
  logic [2:0]          lvl_q;
  logic [2:0]          lvl_d;
  logic                start_evt;
  logic                end_evt;
  logic                rise_evt;
  logic                fall_evt;
  logic                sdi;
  sdg_pkg::sdg_phase_t phase_q;
  logic [6:0]          bits_q;
  logic [6:0]          shreg_q;
  logic [7:0]          byte_in;
  logic [7:0]          cmd_q;
  logic                rd_q;
  logic                cont_q;
  logic                crc_on_q;
  logic                cmd_done_q;
  logic                load_q;
  logic [2:0]          byte_idx_q;
  logic [2:0]          width_q;
  logic                valid_q;
  logic                ro_q;
  logic [31:0]         wdata_q;
  logic [7:0]          crc_q;
  logic [7:0]          crc_nx;
  logic [31:0]         rd_word_q;
  logic [39:0]         out_q;
  logic                oe_q;
  logic                last;
  logic                busy;
  logic [31:0]         rdata;
  logic [31:0]         rd_left;
  logic [2:0]          need_bytes;
  logic [6:0]          need_bits;
  logic                wr_frame;
  logic                short;
  logic                cnt_bad;
  logic                bad_addr;
  logic                crc_bad;
  logic                commit;
  logic [sdg_pkg::N_FAULTS-1:0] faults_q;
  logic [sdg_pkg::N_FAULTS-1:0] fault_set;
  logic                cont_prev_q;
  logic                recompute;
  logic                rom_fault;
  logic                map_fault;

  // Three-stage sampling of SCLK, CS_N, SDI; a change counts when stages 2 and 3 agree
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      s1_q <= sdg_pkg::SYNC_IDLE;
      s2_q <= sdg_pkg::SYNC_IDLE;
      s3_q <= sdg_pkg::SYNC_IDLE;
      lvl_q <= sdg_pkg::SYNC_IDLE;
    end else begin
      s1_q <= {SCLK, CS_N, SDI};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // Edge events from the filtered levels
  assign lvl_d = (s3_q & ~(s3_q ^ s2_q)) | (lvl_q & (s3_q ^ s2_q));
  assign start_evt = !lvl_d[1] && lvl_q[1];
  assign end_evt = lvl_d[1] && !lvl_q[1];
  assign rise_evt = lvl_d[2] && !lvl_q[2] && !lvl_q[1];
  assign fall_evt = !lvl_d[2] && lvl_q[2] && !lvl_q[1];
  assign sdi = lvl_d[0];
  assign byte_in = {shreg_q, sdi};
  assign crc_nx = sdg_pkg::crc8(crc_q, rd_q ? rd_word_q[31:24] : byte_in);
  assign last = (byte_idx_q == 3'(width_q - 3'h1));
  assign busy = LOADING || CALIBRATING || SEQUENCE_BUSY;

  // Frame sequencing, byte assembly and running checksum
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      phase_q <= sdg_pkg::PH_DONE;
      bits_q <= 7'h00;
      shreg_q <= 7'h00;
      cmd_q <= 8'h00;
      rd_q <= 1'h0;
      cont_q <= 1'h0;
      crc_on_q <= 1'h0;
      cmd_done_q <= 1'h0;
      load_q <= 1'h0;
      byte_idx_q <= 3'h0;
      wdata_q <= 32'h0;
      crc_q <= sdg_pkg::CRC_INIT;
    end else begin
      load_q <= 1'h0;
      if (start_evt) begin
        bits_q <= 7'h00;
        byte_idx_q <= 3'h0;
        wdata_q <= 32'h0;
        cont_q <= CONTINUOUS_READOUT;
        crc_on_q <= CHECKSUM_ENABLE;
        if (CONTINUOUS_READOUT) begin
          cmd_q <= sdg_pkg::CONT_CMD;
          rd_q <= 1'h1;
          cmd_done_q <= 1'h1;
          load_q <= 1'h1;
          phase_q <= sdg_pkg::PH_DATA;
          crc_q <= sdg_pkg::crc8(sdg_pkg::CRC_INIT, sdg_pkg::CONT_CMD);
        end else begin
          cmd_q <= 8'h00;
          rd_q <= 1'h0;
          cmd_done_q <= 1'h0;
          phase_q <= sdg_pkg::PH_CMD;
          crc_q <= sdg_pkg::CRC_INIT;
        end
      end else if (rise_evt) begin
        if (CLOCK_COUNT_CHECK_ENABLE && bits_q != sdg_pkg::BITS_MAX) begin
          bits_q <= bits_q + 7'h01;
        end else if (bits_q != sdg_pkg::BITS_MAX) begin
          bits_q <= bits_q + 7'h01;
        end
        shreg_q <= byte_in[6:0];
        if (bits_q[2:0] == 3'h7) begin
          case (phase_q)
            sdg_pkg::PH_CMD: begin
              cmd_q <= byte_in;
              rd_q <= byte_in[sdg_pkg::CMD_READ_BIT];
              cmd_done_q <= 1'h1;
              load_q <= 1'h1;
              crc_q <= crc_nx;
              phase_q <= sdg_pkg::PH_DATA;
            end
            sdg_pkg::PH_DATA: begin
              crc_q <= crc_nx;
              wdata_q <= {wdata_q[23:0], byte_in};
              byte_idx_q <= byte_idx_q + 3'h1;
              if (last) begin
                phase_q <= crc_on_q ? sdg_pkg::PH_CRC : sdg_pkg::PH_DONE;
              end
            end
            sdg_pkg::PH_CRC: begin
              crc_q <= sdg_pkg::crc8(crc_q, byte_in);
              phase_q <= sdg_pkg::PH_DONE;
            end
            default: phase_q <= sdg_pkg::PH_DONE;
          endcase
        end
      end
    end
  end

  // Read data: zero when blocked or the address is unmapped with checking on
  always_comb begin
    rdata = REG_RDATA;
    if (busy || (READ_CHECK_ENABLE && !REG_VALID)) begin
      rdata = 32'h0;
    end
    case (REG_WIDTH)
      3'h1:    rd_left = {rdata[7:0], 24'h0};
      3'h2:    rd_left = {rdata[15:0], 16'h0};
      3'h3:    rd_left = {rdata[23:0], 8'h0};
      default: rd_left = rdata;
    endcase
  end

  // Output shifter: load after the command, shift on falling SCLK, splice checksum
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      out_q <= 40'h0;
      oe_q <= 1'h0;
      rd_word_q <= 32'h0;
      width_q <= sdg_pkg::WIDTH_RST;
      valid_q <= 1'h0;
      ro_q <= 1'h0;
    end else begin
      if (end_evt || start_evt) begin
        oe_q <= 1'h0;
      end else if (load_q) begin
        width_q <= REG_WIDTH;
        valid_q <= REG_VALID;
        ro_q <= REG_READ_ONLY;
        if (rd_q) begin
          rd_word_q <= rd_left;
          out_q <= cont_q ? {rd_left, 8'h00} : {1'h0, rd_left, 7'h00};
          oe_q <= 1'h1;
        end
      end else if (rise_evt && rd_q && phase_q == sdg_pkg::PH_DATA && bits_q[2:0] == 3'h7) begin
        rd_word_q <= {rd_word_q[23:0], 8'h00};
        if (last && crc_on_q) begin
          out_q <= {out_q[39], crc_nx, 31'h0};
        end
      end else if (fall_evt && oe_q) begin
        out_q <= {out_q[38:0], 1'h0};
      end
    end
  end

  assign SDO = out_q[39];
  assign SDO_OE = oe_q;
  assign REG_ADDR = cmd_q[sdg_pkg::ADDR_W-1:0];

  // Frame-end checks on a write
  assign need_bytes = 3'(width_q + (crc_on_q ? 3'h2 : 3'h1));
  assign need_bits = {1'h0, need_bytes, 3'h0};
  assign wr_frame = !lvl_q[1] && cmd_done_q && !rd_q;
  assign short = bits_q < need_bits;
  assign cnt_bad = CLOCK_COUNT_CHECK_ENABLE && bits_q[2:0] != 3'h0;
  assign bad_addr = !valid_q || ro_q;
  assign crc_bad = crc_on_q && crc_q != 8'h00;
  assign commit = end_evt && wr_frame && !short && !cnt_bad && !crc_bad && !bad_addr
                  && !faults_q[sdg_pkg::F_IGN] && !busy;

  // Register write strobe and data
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      REG_WE <= 1'h0;
      REG_WDATA <= 32'h0;
    end else begin
      REG_WE <= commit;
      if (commit) begin
        REG_WDATA <= wdata_q;
      end
    end
  end

  // Fault set terms
  always_comb begin
    fault_set = '0;
    fault_set[sdg_pkg::F_CLK] = end_evt && !lvl_q[1] && cnt_bad;
    fault_set[sdg_pkg::F_RD] = load_q && rd_q && READ_CHECK_ENABLE && !REG_VALID;
    fault_set[sdg_pkg::F_WR] = end_evt && wr_frame && WRITE_CHECK_ENABLE && bad_addr;
    fault_set[sdg_pkg::F_IGN] = busy && !IGNORE_CHECK_DISABLE;
    fault_set[sdg_pkg::F_CRC] = end_evt && wr_frame && !short && crc_bad;
    fault_set[sdg_pkg::F_MAP] = map_fault;
    fault_set[sdg_pkg::F_ROM] = rom_fault;
  end

  // Sticky faults, write-one-to-clear, a set in the same cycle wins
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      faults_q <= sdg_pkg::FAULT_RST;
    end else begin
      faults_q <= (faults_q & ~FAULT_CLEAR) | fault_set;
    end
  end

  assign CLOCK_COUNT_FAULT = faults_q[sdg_pkg::F_CLK];
  assign READ_FAULT = faults_q[sdg_pkg::F_RD];
  assign WRITE_FAULT = faults_q[sdg_pkg::F_WR];
  assign IGNORE_FAULT = faults_q[sdg_pkg::F_IGN];
  assign CHECKSUM_FAULT = faults_q[sdg_pkg::F_CRC];
  assign REGMAP_CHECKSUM_FAULT = faults_q[sdg_pkg::F_MAP];
  assign ROM_CHECKSUM_FAULT = faults_q[sdg_pkg::F_ROM];

  // Map checksum retake triggers and master clock hold
  assign recompute = REG_WE || CAL_DONE || SEQ_STANDBY_ENTRY
                     || (cont_prev_q && !CONTINUOUS_READOUT);
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      cont_prev_q <= 1'h0;
      KEEP_CLOCK_ALIVE <= 1'h0;
    end else begin
      cont_prev_q <= CONTINUOUS_READOUT;
      KEEP_CLOCK_ALIVE <= ROM_CHECK_ENABLE && MASTER_CLOCK_ENABLE;
    end
  end

  // Background ROM and register-map walker
  sdg_scan #(
    .ROM_BYTES (ROM_BYTES),
    .MAP_BYTES (MAP_BYTES),
    .PERIOD    (REGMAP_PERIOD)
  ) u_scan (
    .clk          (CORE_CLK),
    .rst_n        (RESET_N),
    .rom_addr     (ROM_ADDR),
    .rom_data     (ROM_DATA),
    .rom_ref      (ROM_CHECKSUM_REF),
    .map_addr     (MAP_ADDR),
    .map_data     (MAP_DATA),
    .map_skip     (MAP_SKIP),
    .recompute    (recompute),
    .rom_check_en (ROM_CHECK_ENABLE),
    .map_check_en (REGMAP_CHECKSUM_ENABLE),
    .loading      (LOADING),
    .rom_fault    (rom_fault),
    .map_fault    (map_fault)
  );

  // Assertions
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_write_end;
    end_evt && wr_frame;
  endsequence

  property p_cnt;
    end_evt && !lvl_q[1] && CLOCK_COUNT_CHECK_ENABLE && bits_q[2:0] != 3'h0
      |=> CLOCK_COUNT_FAULT;
  endproperty
  a_cnt: assert property (p_cnt) else $error("pulse count fault not raised");

  property p_short;
    s_write_end and short |=> !REG_WE;
  endproperty
  a_short: assert property (p_short) else $error("short write reached register");

  property p_rdzero;
    load_q && rd_q && READ_CHECK_ENABLE && !REG_VALID |=> READ_FAULT && rd_word_q == 32'h0;
  endproperty
  a_rdzero: assert property (p_rdzero) else $error("bad read not zeroed");

  property p_wrbad;
    s_write_end and WRITE_CHECK_ENABLE && bad_addr |=> !REG_WE && WRITE_FAULT;
  endproperty
  a_wrbad: assert property (p_wrbad) else $error("bad write not aborted");

  property p_ign;
    busy && !IGNORE_CHECK_DISABLE |=> IGNORE_FAULT;
  endproperty
  a_ign: assert property (p_ign) else $error("ignore fault not raised");

  property p_ignwr;
    s_write_end and IGNORE_FAULT |=> !REG_WE;
  endproperty
  a_ignwr: assert property (p_ignwr) else $error("write taken while ignored");

  property p_crc;
    s_write_end and !short && crc_bad |=> !REG_WE && CHECKSUM_FAULT;
  endproperty
  a_crc: assert property (p_crc) else $error("bad checksum write taken");

  property p_alive;
    ROM_CHECK_ENABLE && MASTER_CLOCK_ENABLE |=> KEEP_CLOCK_ALIVE;
  endproperty
  a_alive: assert property (p_alive) else $error("master clock hold missing");
endmodule
`default_nettype wire

// [sdg_pkg.sv]
// Constants, types and the checksum step shared by the serial diagnostics block
package sdg_pkg;
  // Core clock and register-map check period
  localparam int CLK_HZ = 10_000_000;
  localparam int REGMAP_RATE_HZ = 300;
  localparam int REGMAP_PERIOD_CYC = CLK_HZ / REGMAP_RATE_HZ;
  // Command byte layout
  localparam int ADDR_W = 6;
  localparam int CMD_READ_BIT = 6;
  localparam logic [7:0] CONT_CMD = 8'h42;
  // Checksum generator and start value
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Reset values, pulse-count ceiling and default ROM and map sizes
  localparam logic [2:0] SYNC_IDLE = 3'h2;
  localparam logic [6:0] BITS_MAX = 7'h7F;
  localparam logic [2:0] WIDTH_RST = 3'h1;
  localparam logic [6:0] FAULT_RST = 7'h00;
  localparam int ROM_BYTES_DEF = 64;
  localparam int MAP_BYTES_DEF = 64;
  // Fault bit positions
  localparam int F_CLK = 0;
  localparam int F_RD = 1;
  localparam int F_WR = 2;
  localparam int F_IGN = 3;
  localparam int F_CRC = 4;
  localparam int F_MAP = 5;
  localparam int F_ROM = 6;
  localparam int N_FAULTS = 7;

  typedef enum logic [1:0] {
    PH_CMD  = 2'b00,
    PH_DATA = 2'b01,
    PH_CRC  = 2'b10,
    PH_DONE = 2'b11
  } sdg_phase_t;

  typedef enum logic [1:0] {
    SC_ROM  = 2'b00,
    SC_IDLE = 2'b01,
    SC_MAP  = 2'b10
  } sdg_scan_t;

  // One byte through the checksum, MSB first, augmented-zero form
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'h0} ^ CRC_POLY) : {c[6:0], 1'h0};
    end
    return c;
  endfunction
endpackage

// [sdg_scan.sv]
// Background checksum walks over the default ROM and the register map
`timescale 1ns/1ps
`default_nettype none
module sdg_scan #(
  parameter int ROM_BYTES = sdg_pkg::ROM_BYTES_DEF,
  parameter int MAP_BYTES = sdg_pkg::MAP_BYTES_DEF,
  parameter int PERIOD    = sdg_pkg::REGMAP_PERIOD_CYC,
  parameter int RAW       = $clog2(ROM_BYTES),
  parameter int MAW       = $clog2(MAP_BYTES)
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  output logic [RAW-1:0]      rom_addr,
  input  wire logic [7:0]     rom_data,
  input  wire logic [7:0]     rom_ref,
  output logic [MAW-1:0]      map_addr,
  input  wire logic [7:0]     map_data,
  input  wire logic           map_skip,
  input  wire logic           recompute,
  input  wire logic           rom_check_en,
  input  wire logic           map_check_en,
  output logic                loading,
  output logic                rom_fault,
  output logic                map_fault
);
  sdg_pkg::sdg_scan_t state_q;
  logic [7:0]  crc_q;
  logic [7:0]  ref_q;
  logic        capture_q;
  logic        pend_q;
  logic [31:0] tick_q;
  logic [7:0]  rom_nx;
  logic [7:0]  map_nx;
  logic        go_cap;
  logic        go_chk;

  assign rom_nx = sdg_pkg::crc8(crc_q, rom_data);
  assign map_nx = map_skip ? crc_q : sdg_pkg::crc8(crc_q, map_data);
  assign go_cap = (state_q == sdg_pkg::SC_IDLE) && pend_q;
  assign go_chk = (state_q == sdg_pkg::SC_IDLE) && !pend_q && (tick_q == 32'(PERIOD - 1));
  assign loading = (state_q == sdg_pkg::SC_ROM);

  // Recompute requests wait for the walker; a new one beats the take
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= 1'h0;
    end else begin
      pend_q <= recompute || (pend_q && !go_cap);
    end
  end

  // Period counter runs while idle only
  always_ff @(posedge clk) begin
    if (!rst_n || state_q != sdg_pkg::SC_IDLE || go_chk) begin
      tick_q <= 32'h0;
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // Walker: ROM once after reset, then map captures and checks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= sdg_pkg::SC_ROM;
      crc_q <= sdg_pkg::CRC_INIT;
      ref_q <= sdg_pkg::CRC_INIT;
      capture_q <= 1'h1;
      rom_addr <= '0;
      map_addr <= '0;
      rom_fault <= 1'h0;
      map_fault <= 1'h0;
    end else begin
      rom_fault <= 1'h0;
      map_fault <= 1'h0;
      case (state_q)
        sdg_pkg::SC_ROM: begin
          crc_q <= rom_nx;
          rom_addr <= rom_addr + RAW'(1);
          if (rom_addr == RAW'(ROM_BYTES - 1)) begin
            rom_fault <= rom_check_en && (rom_nx != rom_ref);
            crc_q <= sdg_pkg::CRC_INIT;
            state_q <= sdg_pkg::SC_MAP;
          end
        end
        sdg_pkg::SC_MAP: begin
          crc_q <= map_nx;
          map_addr <= map_addr + MAW'(1);
          if (map_addr == MAW'(MAP_BYTES - 1)) begin
            if (capture_q) begin
              ref_q <= map_nx;
            end else begin
              map_fault <= map_check_en && (map_nx != ref_q);
            end
            state_q <= sdg_pkg::SC_IDLE;
          end
        end
        sdg_pkg::SC_IDLE: begin
          crc_q <= sdg_pkg::CRC_INIT;
          map_addr <= '0;
          if (go_cap || go_chk) begin
            capture_q <= go_cap;
            state_q <= sdg_pkg::SC_MAP;
          end
        end
        default: state_q <= sdg_pkg::SC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [sdg_host.sv]
// Host controller model that frames register accesses on the serial port
`timescale 1ns/1ps
`default_nettype none
module sdg_host (
  input  wire logic CORE_CLK,
  output logic      SCLK,
  output logic      CS_N,
  output logic      SDI,
  input  wire logic SDO
);
  localparam int HALF = 4; // Half serial period in core cycles, 800 ns link period
  // Idle link: clock low, frame closed
  initial begin
    SCLK = 1'h0;
    CS_N = 1'h1;
    SDI  = 1'h0;
  end
  // One framed access, mode 0, MSB first; read bits taken just before each fall
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = 64'h0;
    @(posedge CORE_CLK);
    CS_N <= 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      SDI <= tx[i];
      repeat (HALF) @(posedge CORE_CLK);
      SCLK <= 1'h1;
      repeat (HALF) @(posedge CORE_CLK);
      rx = {rx[62:0], SDO};
      SCLK <= 1'h0;
    end
    repeat (HALF) @(posedge CORE_CLK);
    CS_N <= 1'h1;
    SDI  <= ~SDI; // Released line shows no stale value
    repeat (8) @(posedge CORE_CLK);
  endtask
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the serial diagnostics core
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        CORE_CLK = 1'h0;
  logic        RESET_N  = 1'h0;
  logic        cal = 1'h0, ccen = 1'h0, rden = 1'h0, wren = 1'h0, crcen = 1'h0;
  logic        cont = 1'h0, seq = 1'h0, cdone = 1'h0, sbe = 1'h0, igdis = 1'h0;
  logic        mapen = 1'h1, romen = 1'h1, mce = 1'h1;
  logic [6:0]  fclr = 7'h00;
  logic [7:0]  rom_ref = 8'h00;
  logic [31:0] regs [64];
  int          checked = 0, miscompares = 0, cycles = 0;
  wire logic        sclk, cs_n, sdi, sdo, oe, reg_we, loading, keep;
  wire logic [5:0]  reg_addr;
  wire logic [31:0] reg_wdata;
  wire logic [2:0]  rom_addr, map_addr;
  wire logic [6:0]  flt;
  wire logic [7:0]  rom_data = {rom_addr, 5'h11};
  // Register map model: widths, valid range, read-only word, excluded byte
  wire logic [2:0]  reg_width = reg_addr[0] ? 3'h1 : 3'h2;
  wire logic        reg_valid = reg_addr < 6'h20;
  wire logic        reg_ro    = reg_addr == 6'h03;
  wire logic [7:0]  map_data  = regs[{3'h0, map_addr}][7:0];
  wire logic        map_skip  = map_addr == 3'h0;
  sdg_host host_u (.CORE_CLK(CORE_CLK), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo));
  sdg_core #(.REGMAP_PERIOD(50), .ROM_BYTES(8), .MAP_BYTES(8)) dut_u (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi),
    .SDO(sdo), .SDO_OE(oe), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we),
    .REG_RDATA(regs[reg_addr]), .REG_WIDTH(reg_width),
    .REG_VALID(reg_valid), .REG_READ_ONLY(reg_ro),
    .CONTINUOUS_READOUT(cont), .CALIBRATING(cal), .SEQUENCE_BUSY(seq), .CAL_DONE(cdone),
    .SEQ_STANDBY_ENTRY(sbe), .CLOCK_COUNT_CHECK_ENABLE(ccen), .READ_CHECK_ENABLE(rden),
    .WRITE_CHECK_ENABLE(wren), .IGNORE_CHECK_DISABLE(igdis), .CHECKSUM_ENABLE(crcen),
    .REGMAP_CHECKSUM_ENABLE(mapen), .ROM_CHECK_ENABLE(romen), .MASTER_CLOCK_ENABLE(mce),
    .FAULT_CLEAR(fclr), .ROM_ADDR(rom_addr), .ROM_DATA(rom_data), .ROM_CHECKSUM_REF(rom_ref),
    .MAP_ADDR(map_addr), .MAP_DATA(map_data), .MAP_SKIP(map_skip),
    .LOADING(loading), .KEEP_CLOCK_ALIVE(keep), .CLOCK_COUNT_FAULT(flt[0]),
    .READ_FAULT(flt[1]), .WRITE_FAULT(flt[2]), .IGNORE_FAULT(flt[3]),
    .CHECKSUM_FAULT(flt[4]), .REGMAP_CHECKSUM_FAULT(flt[5]), .ROM_CHECKSUM_FAULT(flt[6]));
  // Clock and cycle ceiling
  always #50 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  // Register map behind the port
  always @(posedge CORE_CLK) if (reg_we) regs[reg_addr] <= reg_wdata;
  // Bit-serial checksum step, zero start
  function automatic logic [7:0] cb(input logic [7:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Width-one write; cx spoils the checksum
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [7:0] cx);
    logic [63:0] rx;
    logic [7:0]  c;
    c = cb(cb(8'h00, {2'h0, a}), d) ^ cx;
    if (crcen) host_u.xfer({40'h0, 2'h0, a, d, c}, 24, rx);
    else host_u.xfer({48'h0, 2'h0, a, d}, 16, rx);
  endtask
  task automatic rd(input logic [5:0] a, input int nb, output logic [63:0] rx);
    host_u.xfer({56'h0, 2'h1, a} << nb, 8 + nb, rx);
  endtask
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [63:0] rx;
    for (int i = 0; i < 64; i++) regs[i] = 32'(i * 3);
    for (int i = 0; i < 8; i++) rom_ref = cb(rom_ref, {3'(i), 5'h11});
    rom_ref = rom_ref ^ 8'h01; // Spoiled reference
    repeat (6) @(posedge CORE_CLK);
    RESET_N <= 1'h1;
    for (int i = 0; i < 100 && loading !== 1'h0; i++) @(posedge CORE_CLK);
    repeat (20) @(posedge CORE_CLK);
    chk("ignore", {31'h0, flt[3]}, 32'h1);
    chk("rom", {31'h0, flt[6]}, 32'h1);
    chk("alive", {31'h0, keep}, 32'h1);
    wr(6'h01, 8'h5A, 8'h00);
    chk("drop", regs[1], 32'h3);
    fclr <= 7'h08;
    @(posedge CORE_CLK);
    fclr <= 7'h00;
    repeat (2) @(posedge CORE_CLK);
    chk("ignclr", {31'h0, flt[3]}, 32'h0);
    wr(6'h01, 8'h5A, 8'h00);
    chk("write", regs[1], 32'h5A);
    ccen <= 1'h1;
    host_u.xfer({49'h0, 8'h05, 7'h52}, 15, rx);
    chk("count", {31'h0, flt[0]}, 32'h1);
    chk("short", regs[5], 32'hF);
    rden <= 1'h1;
    rd(6'h30, 16, rx);
    chk("rdflag", {31'h0, flt[1]}, 32'h1);
    chk("rdzero", {16'h0, rx[15:0]}, 32'h0);
    wren <= 1'h1;
    wr(6'h03, 8'hC3, 8'h00);
    chk("wrflag", {31'h0, flt[2]}, 32'h1);
    chk("rdonly", regs[3], 32'h9);
    crcen <= 1'h1;
    @(posedge CORE_CLK);
    wr(6'h05, 8'h81, 8'h00);
    chk("crcok", regs[5], 32'h81);
    wr(6'h05, 8'h18, 8'h01);
    chk("crcflag", {31'h0, flt[4]}, 32'h1);
    chk("crcabort", regs[5], 32'h81);
    rd(6'h01, 16, rx);
    chk("rddata", {24'h0, rx[15:8]}, 32'h5A);
    chk("rdcrc", {24'h0, rx[7:0]}, {24'h0, cb(cb(8'h00, 8'h41), 8'h5A)});
    cont <= 1'h1;
    @(posedge CORE_CLK);
    host_u.xfer(64'h0, 24, rx);
    chk("contdata", {16'h0, rx[23:8]}, 32'h6);
    chk("contcrc", {24'h0, rx[7:0]}, {24'h0, cb(cb(cb(8'h00, 8'h42), 8'h00), 8'h06)});
    chk("oeoff", {31'h0, oe}, 32'h0);
    crcen <= 1'h0;
    cont <= 1'h0;
    cal <= 1'h1;
    @(posedge CORE_CLK);
    wr(6'h07, 8'h77, 8'h00);
    chk("calwr", regs[7], 32'h15);
    chk("calign", {31'h0, flt[3]}, 32'h1);
    cal <= 1'h0;
    fclr <= 7'h08;
    igdis <= 1'h1;
    seq <= 1'h1;
    @(posedge CORE_CLK);
    fclr <= 7'h00;
    wr(6'h07, 8'h77, 8'h00);
    chk("seqwr", regs[7], 32'h15);
    chk("igoff", {31'h0, flt[3]}, 32'h0);
    seq <= 1'h0;
    igdis <= 1'h0;
    mce <= 1'h0;
    repeat (3) @(posedge CORE_CLK);
    chk("alive0", {31'h0, keep}, 32'h0);
    mce <= 1'h1;
    repeat (150) @(posedge CORE_CLK);
    chk("map0", {31'h0, flt[5]}, 32'h0);
    regs[2] = regs[2] ^ 32'h1;
    repeat (150) @(posedge CORE_CLK);
    chk("map1", {31'h0, flt[5]}, 32'h1);
    // Retakes after calibration done and after standby entry adopt the new contents
    cdone <= 1'h1;
    @(posedge CORE_CLK);
    cdone <= 1'h0;
    repeat (30) @(posedge CORE_CLK);
    fclr <= 7'h20;
    @(posedge CORE_CLK);
    fclr <= 7'h00;
    repeat (150) @(posedge CORE_CLK);
    chk("retake", {31'h0, flt[5]}, 32'h0);
    regs[2] = regs[2] ^ 32'h1;
    sbe <= 1'h1;
    @(posedge CORE_CLK);
    sbe <= 1'h0;
    repeat (30) @(posedge CORE_CLK);
    fclr <= 7'h20;
    @(posedge CORE_CLK);
    fclr <= 7'h00;
    repeat (150) @(posedge CORE_CLK);
    chk("retake2", {31'h0, flt[5]}, 32'h0);
    mapen <= 1'h0;
    regs[2] = regs[2] ^ 32'h1;
    repeat (150) @(posedge CORE_CLK);
    chk("mapoff", {31'h0, flt[5]}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
